// [fll_tuner_map.vh]
`ifndef FLL_TUNER_MAP_VH
`define FLL_TUNER_MAP_VH
// Code widths
`define FINE_W 8
`define COARSE_W 5
`define MUL_W 16
`define AMP_W 5
`define STEP_W 5
// Reference-stop limit, in output clock cycles
`define REF_STOP_LIMIT 65536
// Fine start value: half of full scale
`define FINE_HALF 8'h80
// Lock windows on ratio error
`define STRICT_WIN 16'h0001
`define RELAXED_WIN 16'h0004
// LFSR reset seed
`define PSEUDO_RANDOM_GATE_SEED 15'h7fff
`endif

// [spread_gen.v]
`timescale 1ns/100ps
`include "fll_tuner_map.vh"
// Spread generator: triangle offset with optional pseudo-random tick gating
module spread_gen #(
   parameter AMP_W = `AMP_W,
   parameter STEP_W = `STEP_W
) (
   input wire clock,
   input wire arst_n,
   input wire enable,
   input wire prbsEnable,
   input wire tick,
   input wire [AMP_W-1:0] amplitude,
   input wire [STEP_W-1:0] spread_step,
   output reg signed [AMP_W+1:0] offset
);
   localparam signed [AMP_W+1:0] OFS_ZERO = 0;
   localparam signed [AMP_W+1:0] OFS_ONE = 1;
   localparam signed [AMP_W+1:0] OFS_MINUS = -1;
   reg [14:0] lfsr_q;
   reg down_q;
   reg [1:0] phase_q;
   wire qualified;
   wire signed [AMP_W+1:0] stepVal;
   wire signed [AMP_W+1:0] ampVal;
   // Step of zero or one acts as one
   assign stepVal = (spread_step < 2) ? OFS_ONE : $signed({2'b00, spread_step});
   assign ampVal = $signed({2'b00, amplitude});
   assign qualified = tick & (~prbsEnable | lfsr_q[0]);
   // Offset sequence per amplitude
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lfsr_q <= `PSEUDO_RANDOM_GATE_SEED;
         down_q <= 1'b0;
         phase_q <= 2'd0;
         offset <= OFS_ZERO;
      end else begin
         if (tick) begin
            lfsr_q <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
         end
         if (!enable) begin
            offset <= OFS_ZERO;
            phase_q <= 2'd0;
            down_q <= 1'b0;
         end else if (qualified) begin
            if (amplitude == 0) begin
               offset <= (offset == OFS_ZERO) ? OFS_ONE : OFS_ZERO;
            end else if (amplitude == 1) begin
               // Repeating 1, -1, 0
               phase_q <= (phase_q == 2'd2) ? 2'd0 : phase_q + 2'd1;
               offset <= (phase_q == 2'd0) ? OFS_ONE : (phase_q == 2'd1) ? OFS_MINUS : OFS_ZERO;
            end else if (!down_q) begin
               if (offset + stepVal >= ampVal) begin
                  offset <= ampVal;
                  down_q <= 1'b1;
               end else begin
                  offset <= offset + stepVal;
               end
            end else begin
               if (offset - stepVal <= -ampVal) begin
                  offset <= -ampVal;
                  down_q <= 1'b0;
               end else begin
                  offset <= offset - stepVal;
               end
            end
         end
      end
   end
endmodule // spread_gen

// [freq_loop_tuner_ctrl.v]
`timescale 1ns/100ps
`include "fll_tuner_map.vh"
// Functional notes
// - Flag reference stopped after long silence
// - Stopped reference: hold codes, auto resume
// - Pulse on stopped flag rising edge
// - Chill cycles unless disable bit set
// - Relaxed lock unless disable bit set
// - Spread enable modulates fine code
// - Pseudo-random sequence gates spread ticks
// - Step n per tick, zero acts one
// - Amplitude zero toggles, one gives 1,-1,0
// - Spread works open and closed loop
// - No lose-lock: wake keeps config and locks
// - After wake, fine tracking corrects drift
// - Lose-lock set: wake clears locks, relock
// - Mode bit starts closed-loop tuning
// - Coarse then fine stage, rise pulses
// - Stable bit freezes fine after lock
// - Fine starts at half scale unless start load set
module freq_loop_tuner_ctrl #(
   parameter FINE_W = `FINE_W,
   parameter COARSE_W = `COARSE_W,
   parameter MUL_W = `MUL_W,
   parameter AMP_W = `AMP_W,
   parameter STEP_W = `STEP_W,
   parameter REF_STOP_LIMIT = `REF_STOP_LIMIT
) (
   input wire clock,
   input wire arst_n,
   input wire refTick,
   input wire spreadTick,
   input wire closedLoopMode,
   input wire chillCycleDisable,
   input wire quickLockDisable,
   input wire stable,
   input wire loseLockOnWake,
   input wire [MUL_W-1:0] multiplier,
   input wire [COARSE_W-1:0] coarseStep,
   input wire [FINE_W-1:0] fineStep,
   input wire fineStartLoad,
   input wire [FINE_W-1:0] fineStartValue,
   input wire [COARSE_W-1:0] coarseOpen,
   input wire [FINE_W-1:0] fineOpen,
   input wire sleepEnter,
   input wire wake,
   input wire spreadEnable,
   input wire prbsEnable,
   input wire [AMP_W-1:0] amplitude,
   input wire [STEP_W-1:0] spreadStep,
   output reg [COARSE_W-1:0] coarseCode,
   output reg [FINE_W-1:0] fineCode,
   output reg refStoppedFlag,
   output reg refStoppedRise,
   output reg coarseLockFlag,
   output reg coarseLockRise,
   output reg fineLockFlag,
   output reg fineLockRise,
   output reg [MUL_W-1:0] ratioDiff
);
   localparam ST_IDLE = 2'd0;
   localparam ST_COARSE = 2'd1;
   localparam ST_FINE = 2'd2;
   localparam [31:0] LIMIT = REF_STOP_LIMIT;
   reg [1:0] state_q;
   reg [31:0] stopCnt_q;
   reg [MUL_W-1:0] measCnt_q;
   reg chill_q;
   reg modeSeen_q;
   reg asleep_q;
   reg dropLocks_q;
   reg [COARSE_W-1:0] coarse_q;
   reg [FINE_W-1:0] fine_q;
   wire signed [AMP_W+1:0] spreadOffset;
   wire signed [MUL_W:0] err;
   wire [MUL_W-1:0] absErr;
   wire [MUL_W-1:0] lockWin;
   wire measure;
   wire active;
   // Saturating add of a signed offset to the fine code
   function [FINE_W-1:0] satAdd;
      input [FINE_W-1:0] base;
      input signed [MUL_W+1:0] delta;
      reg signed [MUL_W+2:0] sum;
      begin
         sum = $signed({3'b000, base}) + delta;
         if (sum < 0) begin
            satAdd = {FINE_W{1'b0}};
         end else if (sum > $signed({{(MUL_W+3-FINE_W){1'b0}}, {FINE_W{1'b1}}})) begin
            satAdd = {FINE_W{1'b1}};
         end else begin
            satAdd = sum[FINE_W-1:0];
         end
      end
   endfunction

   spread_gen #(.AMP_W(AMP_W), .STEP_W(STEP_W)) spreadInst (
      .clock(clock),
      .arst_n(arst_n),
      .enable(spreadEnable),
      .prbsEnable(prbsEnable),
      .tick(spreadTick),
      .amplitude(amplitude),
      .spread_step(spreadStep),
      .offset(spreadOffset)
   );

   // Ratio error and lock window
   assign err = $signed({1'b0, measCnt_q}) - $signed({1'b0, multiplier});
   assign absErr = err[MUL_W] ? -err[MUL_W-1:0] : err[MUL_W-1:0];
   assign lockWin = quickLockDisable ? `STRICT_WIN : `RELAXED_WIN;
   assign active = closedLoopMode & ~refStoppedFlag & ~asleep_q;
   assign measure = refTick & active & ~(chill_q & ~chillCycleDisable);

   // Reference-stop watchdog and measurement counter
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stopCnt_q <= 32'd0;
         measCnt_q <= {MUL_W{1'b0}};
         refStoppedFlag <= 1'b0;
         refStoppedRise <= 1'b0;
         chill_q <= 1'b0;
      end else begin
         refStoppedRise <= 1'b0;
         if (refTick) begin
            stopCnt_q <= 32'd0;
            refStoppedFlag <= 1'b0;
            measCnt_q <= {{(MUL_W-1){1'b0}}, 1'b1};
            chill_q <= measure ? 1'b1 : 1'b0;
         end else begin
            measCnt_q <= (&measCnt_q) ? measCnt_q : measCnt_q + 1'b1;
            if (stopCnt_q >= LIMIT - 1) begin
               if (!refStoppedFlag && closedLoopMode) begin
                  refStoppedFlag <= 1'b1;
                  refStoppedRise <= 1'b1;
               end
            end else begin
               stopCnt_q <= stopCnt_q + 32'd1;
            end
         end
      end
   end

   // Tuner state machine
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         coarse_q <= {COARSE_W{1'b0}};
         fine_q <= `FINE_HALF;
         modeSeen_q <= 1'b0;
         asleep_q <= 1'b0;
         dropLocks_q <= 1'b0;
         coarseLockFlag <= 1'b0;
         fineLockFlag <= 1'b0;
         coarseLockRise <= 1'b0;
         fineLockRise <= 1'b0;
         ratioDiff <= {MUL_W{1'b0}};
      end else begin
         coarseLockRise <= 1'b0;
         fineLockRise <= 1'b0;
         modeSeen_q <= closedLoopMode;
         if (sleepEnter) begin
            asleep_q <= 1'b1;
            dropLocks_q <= loseLockOnWake;
         end else if (wake && asleep_q) begin
            asleep_q <= 1'b0;
            if (dropLocks_q) begin
               coarseLockFlag <= 1'b0;
               fineLockFlag <= 1'b0;
               fine_q <= `FINE_HALF;
               state_q <= ST_COARSE;
            end
         end else if (!closedLoopMode) begin
            state_q <= ST_IDLE;
            coarse_q <= coarseOpen;
            fine_q <= fineOpen;
            coarseLockFlag <= 1'b0;
            fineLockFlag <= 1'b0;
         end else if (!modeSeen_q) begin
            fine_q <= fineStartLoad ? fineStartValue : `FINE_HALF;
            state_q <= ST_COARSE;
         end else if (measure) begin
            ratioDiff <= err[MUL_W-1:0];
            case (state_q)
               ST_COARSE: begin
                  if (absErr <= (lockWin << 3)) begin
                     coarseLockFlag <= 1'b1;
                     coarseLockRise <= 1'b1;
                     state_q <= ST_FINE;
                  end else if (err[MUL_W]) begin
                     coarse_q <= (coarse_q > ~coarseStep) ? {COARSE_W{1'b1}} :
                        coarse_q + coarseStep;
                  end else begin
                     coarse_q <= (coarse_q < coarseStep) ? {COARSE_W{1'b0}} :
                        coarse_q - coarseStep;
                  end
               end
               ST_FINE: begin
                  if (!(fineLockFlag && stable)) begin
                     if (absErr <= lockWin) begin
                        if (!fineLockFlag) begin
                           fineLockFlag <= 1'b1;
                           fineLockRise <= 1'b1;
                        end
                     end else if (err[MUL_W]) begin
                        fine_q <= satAdd(fine_q, $signed({2'b00, fineStep}));
                     end else begin
                        fine_q <= satAdd(fine_q, -$signed({2'b00, fineStep}));
                     end
                  end
               end
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Registered trim codes, spread offset applied to the fine code only
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         coarseCode <= {COARSE_W{1'b0}};
         fineCode <= `FINE_HALF;
      end else begin
         coarseCode <= coarse_q;
         fineCode <= satAdd(fine_q, spreadOffset);
      end
   end
endmodule // freq_loop_tuner_ctrl

// [freq_loop_tuner_ctrl_sva.sv]
`timescale 1ns/100ps
`include "fll_tuner_map.vh"
// Port-level checks on the loop tuner control
module freq_loop_tuner_ctrl_sva #(
   parameter FINE_W = 8,
   parameter REF_STOP_LIMIT = 64
) (
   input wire clock,
   input wire arst_n,
   input wire refTick,
   input wire closedLoopMode,
   input wire stable,
   input wire loseLockOnWake,
   input wire fineStartLoad,
   input wire wake,
   input wire spreadEnable,
   input wire [FINE_W-1:0] fineCode,
   input wire refStoppedFlag,
   input wire refStoppedRise,
   input wire coarseLockFlag,
   input wire coarseLockRise,
   input wire fineLockFlag,
   input wire fineLockRise
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   int quietCnt;
   // Cycles since the last reference tick while in closed loop
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) quietCnt <= 0;
      else quietCnt <= (refTick || !closedLoopMode) ? 0 : quietCnt + 1;
   end
   stop_rise_pulse_a: assert property ($rose(refStoppedFlag) |-> refStoppedRise)
      else $error("stopped rise pulse missing");
   stop_after_quiet_a: assert property ($rose(refStoppedFlag) |-> quietCnt >= REF_STOP_LIMIT - 2)
      else $error("stopped flag too early");
   stop_clear_tick_a: assert property (refTick |=> !refStoppedFlag)
      else $error("stopped flag kept after tick");
   coarse_rise_a: assert property ($rose(coarseLockFlag) |-> coarseLockRise)
      else $error("coarse rise pulse missing");
   fine_rise_a: assert property (fineLockRise |-> fineLockFlag && !$past(fineLockFlag))
      else $error("fine rise pulse wrong");
   fine_after_coarse_a: assert property (fineLockFlag |-> coarseLockFlag)
      else $error("fine lock without coarse");
   open_clears_a: assert property (!closedLoopMode [*2] |-> !coarseLockFlag && !fineLockFlag)
      else $error("locks kept in open loop");
   fine_freeze_a: assert property ((stable && fineLockFlag && closedLoopMode && !spreadEnable) [*3]
      |-> $stable(fineCode)) else $error("fine moved while frozen");
   fine_half_a: assert property ($rose(closedLoopMode) && !fineStartLoad && !spreadEnable
      ##1 !refTick [*3] |-> fineCode == `FINE_HALF) else $error("fine start wrong");
   wake_keep_a: assert property (wake && !loseLockOnWake && fineLockFlag |=> fineLockFlag)
      else $error("lock lost on wake");
   wake_lose_a: assert property (wake && loseLockOnWake |-> ##2 !coarseLockFlag)
      else $error("lock kept on wake");
   cover property (fineLockRise);
   cover property ($rose(refStoppedFlag));
   cover property (wake && loseLockOnWake);
endmodule // freq_loop_tuner_ctrl_sva

bind freq_loop_tuner_ctrl freq_loop_tuner_ctrl_sva #(.FINE_W(FINE_W),
   .REF_STOP_LIMIT(REF_STOP_LIMIT)) u_sva (.clock(clock), .arst_n(arst_n), .refTick(refTick),
   .closedLoopMode(closedLoopMode), .stable(stable), .loseLockOnWake(loseLockOnWake),
   .fineStartLoad(fineStartLoad), .wake(wake), .spreadEnable(spreadEnable),
   .fineCode(fineCode), .refStoppedFlag(refStoppedFlag), .refStoppedRise(refStoppedRise),
   .coarseLockFlag(coarseLockFlag), .coarseLockRise(coarseLockRise),
   .fineLockFlag(fineLockFlag), .fineLockRise(fineLockRise));

// [freq_loop_tuner_ctrl_tb.sv]
`timescale 1ns/100ps
module freq_loop_tuner_ctrl_tb;
   logic clock = 0, arst_n = 0, refTick = 0, spreadTick = 0, closedLoopMode = 0;
   logic chillCycleDisable = 0, quickLockDisable = 0, stable = 0, loseLockOnWake = 0;
   logic fineStartLoad = 0, sleepEnter = 0, wake = 0, spreadEnable = 0, prbsEnable = 0;
   logic [15:0] multiplier = 16'h0014;
   logic [4:0] coarseOpen = 5'h10, amplitude = 5'h00, spreadStep = 5'h00;
   logic [7:0] fineOpen = 8'h40, lo, hi;
   logic [7:0] s [0:23];
   wire [4:0] coarseCode;
   wire [7:0] fineCode;
   wire [15:0] ratioDiff;
   wire refStoppedFlag, refStoppedRise, coarseLockFlag, coarseLockRise, fineLockFlag, fineLockRise;
   int miscompares = 0, cmp_count = 0, refPeriod = 0, refCnt = 0, rises = 0, t1, t2, chg;
   int steps [4] = '{0, 1, 2, 4};
   int fills [2] = '{255, 0};
   freq_loop_tuner_ctrl #(.REF_STOP_LIMIT(64)) u_freq_loop_tuner_ctrl (.clock(clock),
      .arst_n(arst_n), .refTick(refTick), .spreadTick(spreadTick),
      .closedLoopMode(closedLoopMode), .chillCycleDisable(chillCycleDisable),
      .quickLockDisable(quickLockDisable), .stable(stable), .loseLockOnWake(loseLockOnWake),
      .multiplier(multiplier), .coarseStep(5'h04), .fineStep(8'h08),
      .fineStartLoad(fineStartLoad), .fineStartValue(8'h20), .coarseOpen(coarseOpen),
      .fineOpen(fineOpen), .sleepEnter(sleepEnter), .wake(wake), .spreadEnable(spreadEnable),
      .prbsEnable(prbsEnable), .amplitude(amplitude), .spreadStep(spreadStep),
      .coarseCode(coarseCode), .fineCode(fineCode), .refStoppedFlag(refStoppedFlag),
      .refStoppedRise(refStoppedRise), .coarseLockFlag(coarseLockFlag),
      .coarseLockRise(coarseLockRise), .fineLockFlag(fineLockFlag),
      .fineLockRise(fineLockRise), .ratioDiff(ratioDiff));
   // Clock and reference tick source
   always #4 clock = ~clock;
   always @(posedge clock) begin
      if (refStoppedRise === 1'b1) rises++;
      #1;
      refCnt = (refPeriod != 0 && refCnt + 1 < refPeriod) ? refCnt + 1 : 0;
      refTick = (refPeriod != 0 && refCnt == 0);
   end
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic lock(output int t);
      closedLoopMode = 0;
      cyc(3);
      closedLoopMode = 1;
      for (t = 0; t < 2000 && fineLockFlag !== 1'b1; t++) cyc(1);
   endtask
   task automatic nap(input logic lose);
      loseLockOnWake = lose;
      sleepEnter = 1;
      cyc(1);
      sleepEnter = 0;
      refPeriod = 0;
      cyc(20);
      wake = 1;
      cyc(1);
      wake = 0;
      cyc(3);
      check(fineLockFlag, !lose, "wake lock");
      refPeriod = 20;
   endtask
   task automatic spread(input logic [4:0] amp, input logic [4:0] stp, input logic pseudo_random_gate,
      input int n);
      spreadEnable = 0;
      cyc(3);
      amplitude = amp;
      spreadStep = stp;
      prbsEnable = pseudo_random_gate;
      spreadEnable = 1;
      cyc(3);
      for (int i = 0; i < n; i++) begin
         spreadTick = 1;
         cyc(1);
         spreadTick = 0;
         cyc(4);
         s[i] = fineCode;
      end
   endtask
   // Watchdog
   initial begin
      #500000;
      miscompares++;
      end_sim();
   end
   // Test sequence
   initial begin
      cyc(3);
      arst_n = 1;
      check(fineCode, 8'h80, "fine reset");
      refPeriod = 20;
      lock(t1);
      check(fineLockFlag, 1, "lock");
      chillCycleDisable = 1;
      lock(t2);
      check(t2 < t1, 1, "chill");
      multiplier = 16'h0017;
      chillCycleDisable = 0;
      quickLockDisable = 1;
      lock(t2);
      check(fineLockFlag, 0, "strict");
      check(ratioDiff, 16'hfffd, "ratio");
      quickLockDisable = 0;
      lock(t2);
      check(fineLockFlag, 1, "relaxed");
      multiplier = 16'h001a;
      t1 = fineCode;
      cyc(100);
      check(fineCode != 8'(t1), 1, "drift");
      multiplier = 16'h0017;
      stable = 1;
      cyc(60);
      nap(0);
      nap(1);
      cyc(1500);
      check(fineLockFlag, 1, "relock");
      refPeriod = 0;
      rises = 0;
      cyc(40);
      check(refStoppedFlag, 0, "early");
      cyc(60);
      check(refStoppedFlag, 1, "stop");
      check(16'(rises), 1, "rise");
      refPeriod = 20;
      cyc(25);
      check(refStoppedFlag, 0, "resume");
      closedLoopMode = 0;
      spread(0, 0, 0, 4);
      check(coarseCode, 5'h10, "open coarse");
      for (int i = 0; i < 3; i++) begin
         check({s[i][7:1], s[i] != s[i+1]}, {7'h20, 1'b1}, "toggle");
      end
      spread(1, 0, 0, 6);
      for (int i = 0; i < 3; i++) begin
         check(s[i], s[i+3], "period");
      end
      check(16'(s[0]) + s[1] + s[2] + (s[0] != s[1]), 16'h00c1, "sequence");
      for (int k = 0; k < 4; k++) begin
         t1 = steps[k];
         spread(8, 5'(t1), 0, 2);
         check(s[1] > s[0] ? s[1] - s[0] : s[0] - s[1], t1 < 2 ? 1 : t1, "step");
      end
      spread(0, 0, 1, 24);
      chg = 0;
      for (int i = 0; i < 23; i++) chg += (s[i] != s[i+1]);
      check(chg > 0 && chg < 23, 1, "gated");
      for (int k = 0; k < 2; k++) begin
         t2 = fills[k];
         fineOpen = 8'(t2);
         spread(8, 4, 0, 12);
         {lo, hi} = {8'hff, 8'h00};
         for (int i = 0; i < 12; i++) {lo, hi} = {s[i] < lo ? s[i] : lo, s[i] > hi ? s[i] : hi};
         check(t2 != 0 ? lo >= 8'hf0 : hi <= 8'h10, 1, "saturate");
      end
      end_sim();
   end
endmodule // freq_loop_tuner_ctrl_tb
